// *** design/logic_and_branch_exec.v ***
`timescale 1ns/1ps
`include "logic_branch_defines.vh"

module logic_and_branch_exec (
    input wire clk,
    input wire rstn,
    input wire issue,
    input wire [3:0] op,
    input wire delayed,
    input wire [15:0] operand,
    input wire [3:0] shift_count,
    input wire use_long_const,
    input wire has_modifier,
    input wire [1:0] modify,
    input wire load_pointer,
    input wire [2:0] next_pointer,
    input wire old_mode,
    input wire [`ACC_W-1:0] product_reg,
    input wire [1:0] product_shift_field,
    input wire [15:0] dynamic_bit_mask_reg,
    input wire [15:0] mem_rdata,
    input wire word_done,
    output reg [`ACC_W-1:0] acc_q,
    output reg test_flag_q,
    output reg [2:0] aux_reg_pointer_q,
    output reg [15:0] aux_cur,
    output reg mem_we_q,
    output reg [15:0] mem_wdata_q,
    output reg [15:0] pc_q,
    output reg branch_q,
    output reg [1:0] delay_left_q
);

    ////////////////////////////////////////////////////////////////////////
    // Auxiliary register file
    reg [`AR_W-1:0] auxiliary_register [0:`AR_COUNT-1];
    wire [`AR_W-1:0] aux_now;
    wire [`AR_W-1:0] aux_next;
    reg [`ACC_W-1:0] imm_shifted;
    reg [`ACC_W-1:0] prod_shifted;
    wire [15:0] mem_and;
    wire loop_nonzero;
    wire loop_op;
    wire ar_write;
    reg [15:0] pending_target_q;
    integer i;

    assign aux_now = auxiliary_register[aux_reg_pointer_q];
    assign loop_op = (op == `OP_LOOP_BRANCH);

    // Test taken on the old value, before update logic acts
    assign loop_nonzero = old_mode ? (aux_now[8:0] != 9'h000)
                                   : (aux_now != 16'h0000);

    aux_update u_aux_update (
        .value(aux_now),
        .modify(modify),
        .force_dec(loop_op && !has_modifier),
        .result(aux_next)
    );

    // Only OP_BRANCH with a modifier or the loop branch touch the AR
    assign ar_write = issue && (loop_op ||
                      (op == `OP_BRANCH && has_modifier));

    always @* begin
        aux_cur = aux_now;
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath operands
    // Zero-fill both sides of the shifted constant
    always @* begin
        imm_shifted = {16'h0000, operand} << shift_count;
    end

    // Product shift per the status field
    always @* begin
        case (product_shift_field)
            `PM_NONE: prod_shifted = product_reg;
            `PM_LEFT1: prod_shifted = {product_reg[30:0], 1'b0};
            `PM_LEFT4: prod_shifted = {product_reg[27:0], 4'h0};
            `PM_RIGHT6: prod_shifted = {{6{product_reg[31]}},
                                        product_reg[31:6]};
            default: prod_shifted = product_reg;
        endcase
    end

    assign mem_and = mem_rdata & (use_long_const ? operand
                                  : dynamic_bit_mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // Accumulator, flag and memory write-back
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_q <= `ACC_RST;
            test_flag_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_wdata_q <= 16'h0000;
        end else begin
            mem_we_q <= 1'b0;
            if (issue) begin
                case (op)
                    `OP_AND_IMM: begin
                        acc_q <= acc_q & imm_shifted;
                    end
                    `OP_ADD_PROD: begin
                        acc_q <= acc_q + prod_shifted;
                    end
                    `OP_MEM_AND: begin
                        mem_we_q <= 1'b1;
                        mem_wdata_q <= mem_and;
                        test_flag_q <= (mem_and == 16'h0000);
                    end
                    default: begin
                        acc_q <= acc_q;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Auxiliary registers and pointer
    // Pointer load happens after the current AR is modified
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < `AR_COUNT; i = i + 1) begin
                auxiliary_register[i] <= `AR_RST;
            end
            aux_reg_pointer_q <= 3'h0;
        end else if (ar_write) begin
            auxiliary_register[aux_reg_pointer_q] <= aux_next;
            if (has_modifier && load_pointer) begin
                aux_reg_pointer_q <= next_pointer;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Branch sequencing with delay slots
    // A delayed branch waits for two fetched words to complete first;
    // a new branch during the slots is ignored as slots are not nested
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= `PC_RST;
            branch_q <= 1'b0;
            delay_left_q <= 2'h0;
            pending_target_q <= 16'h0000;
        end else begin
            branch_q <= 1'b0;
            if (delay_left_q != 2'h0) begin
                if (word_done) begin
                    if (delay_left_q == 2'h1) begin
                        pc_q <= pending_target_q;
                        branch_q <= 1'b1;
                    end
                    delay_left_q <= delay_left_q - 2'h1;
                end
            end else if (issue && (op == `OP_BRANCH ||
                       op == `OP_BRANCH_ACC ||
                       (loop_op && loop_nonzero))) begin
                if (delayed) begin
                    delay_left_q <= `DELAY_WORDS;
                    pending_target_q <= (op == `OP_BRANCH_ACC) ?
                        acc_q[15:0] : operand;
                end else begin
                    branch_q <= 1'b1;
                    pc_q <= (op == `OP_BRANCH_ACC) ?
                        acc_q[15:0] : operand;
                end
            end
        end
    end

endmodule // logic_and_branch_exec

// *** design/logic_branch_defines.vh ***
`ifndef LOGIC_BRANCH_DEFINES_VH
`define LOGIC_BRANCH_DEFINES_VH

// Operation codes on the op input
`define OP_NONE         4'h0
`define OP_AND_IMM      4'h1
`define OP_ADD_PROD     4'h2
`define OP_MEM_AND      4'h3
`define OP_BRANCH       4'h4
`define OP_BRANCH_ACC   4'h5
`define OP_LOOP_BRANCH  4'h6

// Widths
`define ACC_W           32
`define WORD_W          16
`define AR_W            16
`define ARP_W           3
`define AR_COUNT        8
`define LOOP_TEST_OLD_W 9

// Reset values
`define ACC_RST         32'h0000_0000
`define AR_RST          16'h0000
`define PC_RST          16'h0000

// Delayed branch word count
`define DELAY_WORDS     2'h2

// Indirect modify codes
`define MOD_NONE        2'h0
`define MOD_DEC         2'h1
`define MOD_INC         2'h2

// Product shift field codes
`define PM_NONE         2'h0
`define PM_LEFT1        2'h1
`define PM_LEFT4        2'h2
`define PM_RIGHT6       2'h3

`endif

// *** design/aux_update.v ***
`timescale 1ns/1ps
`include "logic_branch_defines.vh"

// Computes the post-instruction value of one auxiliary register
module aux_update (
    input wire [`AR_W-1:0] value,
    input wire [1:0] modify,
    input wire force_dec,
    output reg [`AR_W-1:0] result
);

    // Plain loop branch decrements by default
    always @* begin
        if (force_dec || modify == `MOD_DEC) begin
            result = value - 16'h0001;
        end else if (modify == `MOD_INC) begin
            result = value + 16'h0001;
        end else begin
            result = value;
        end
    end

endmodule // aux_update

// *** sim/logic_and_branch_exec_checker.sv ***
`timescale 1ns/1ps
module logic_and_branch_exec_checker (
    input wire clk, input wire rstn, input wire issue, input wire delayed,
    input wire [3:0] op, input wire [15:0] operand,
    input wire [3:0] shift_count, input wire use_long_const,
    input wire has_modifier, input wire [15:0] dynamic_bit_mask_reg,
    input wire [15:0] mem_rdata, input wire [31:0] acc_q,
    input wire test_flag_q, input wire [15:0] aux_cur, input wire mem_we_q,
    input wire [15:0] mem_wdata_q, input wire [15:0] pc_q,
    input wire branch_q, input wire [1:0] delay_left_q
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
// Branch issues only count while no delay is pending
wire go = issue && delay_left_q == 2'h0;
wire [15:0] src = use_long_const ? operand : dynamic_bit_mask_reg;
a_and_shifted: assert property (issue && op == 4'h1 |=>
    acc_q == ($past(acc_q) & $past({16'h0, operand} << shift_count)))
    else $error("shifted and wrong");
a_mem_wback: assert property (issue && op == 4'h3 |=>
    mem_we_q && mem_wdata_q == $past(mem_rdata & src))
    else $error("write-back wrong");
a_flag_zero: assert property (mem_we_q |->
    test_flag_q == (mem_wdata_q == 16'h0)) else $error("flag wrong");
a_branch_target: assert property (go && op == 4'h4 && !delayed |=>
    branch_q && pc_q == $past(operand)) else $error("branch wrong");
a_acc_target: assert property (go && op == 4'h5 && !delayed |=>
    branch_q && pc_q == $past(acc_q[15:0])) else $error("acc branch wrong");
// A loop branch on a zero register is not taken, so it opens no slots
a_delay_wait: assert property (go && delayed && op > 4'h3 &&
    op < 4'h7 && (op != 4'h6 || aux_cur[8:0] != 9'h0)
    |=> !branch_q && delay_left_q == 2'h2) else $error("delay wrong");
a_loop_dec: assert property (go && op == 4'h6 && !has_modifier |=>
    aux_cur == $past(aux_cur) - 16'h1) else $error("loop count wrong");
a_loop_zero: assert property (go && op == 4'h6 && aux_cur == 16'h0
    |=> !branch_q) else $error("zero loop taken");
endmodule // logic_and_branch_exec_checker
bind logic_and_branch_exec logic_and_branch_exec_checker chk (.*);

// *** sim/data_mem_model.sv ***
`timescale 1ns/1ps
// Data memory; the bench holds the address across the write-back
module data_mem_model (
    input wire clk,
    input wire [3:0] addr,
    input wire we,
    input wire [15:0] wdata,
    output wire [15:0] rdata
);
reg [15:0] mem [0:15];
integer i;
initial for (i = 0; i < 16; i = i + 1) mem[i] = 16'h5a3c ^ (i * 16'h1111);
always @(posedge clk) if (we) mem[addr] <= wdata;
assign rdata = mem[addr];
endmodule // data_mem_model

// *** sim/logic_and_branch_exec_bench.sv ***
`timescale 1ns/1ps
module logic_and_branch_exec_bench;
reg clk, rstn, issue, delayed, ulc, hm, lp, om, wd;
reg [3:0] op, sc, ad;
reg [15:0] opd, msk, r, ex;
reg [1:0] md, pm;
reg [2:0] np;
reg [31:0] prod, ea;
wire [31:0] acc;
wire [15:0] aux, wdat, pc, rd;
wire tf, we, br;
wire [2:0] aux_reg_pointer;
wire [1:0] dl;
integer failures = 0, checks = 0, i;
reg [15:0] q[$];
logic_and_branch_exec dut (.clk(clk), .rstn(rstn), .issue(issue),
    .op(op), .delayed(delayed), .operand(opd), .shift_count(sc),
    .use_long_const(ulc), .has_modifier(hm), .modify(md),
    .load_pointer(lp), .next_pointer(np), .old_mode(om),
    .product_reg(prod), .product_shift_field(pm),
    .dynamic_bit_mask_reg(msk), .mem_rdata(rd), .word_done(wd),
    .acc_q(acc), .test_flag_q(tf), .aux_reg_pointer_q(aux_reg_pointer), .aux_cur(aux),
    .mem_we_q(we), .mem_wdata_q(wdat), .pc_q(pc), .branch_q(br),
    .delay_left_q(dl));
data_mem_model mem (.clk(clk), .addr(ad), .we(we), .wdata(wdat), .rdata(rd));
function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
task chk(input [31:0] e, input [31:0] s, input [47:0] n); begin
    checks = checks + 1;
    if (e !== s) begin
        failures = failures + 1;
        $display("CHECK FAILED %0s exp %h got %h", n, e, s);
    end
end endtask
task stop_test; begin
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
end endtask
// One op per edge; issue stays high so back-to-back ops never glitch it,
// the caller lowers it before any idle edge
task go(input [3:0] o, input d); begin
    op = o;
    delayed = d;
    issue = 1'b1;
    @(negedge clk);
end endtask
initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
end
// Pulses consume notes in issue order
always @(negedge clk) if (br === 1'b1 || we === 1'b1) begin
    if (q.size() == 0) chk(0, 1, "pulse");
    else chk(q.pop_front(), br ? pc : wdat, "result");
end
initial begin
    #50000;
    failures = failures + 1;
    stop_test;
end
initial begin
    {rstn, issue, delayed, ulc, hm, lp, om, wd, op, sc, ad} = 0;
    {opd, msk, md, pm, np, prod, ea} = 0;
    r = 16'h55fb;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk(32'h0, acc, "acc");
    // Every product shift code, then a shifted mask up to 15
    for (i = 0; i < 4; i = i + 1) begin
        r = nx(r);
        prod = {r, nx(r)};
        pm = i;
        ea = ea + (pm == 2'h3 ? {{6{prod[31]}}, prod[31:6]}
            : prod << (pm == 2'h2 ? 4 : pm));
        go(4'h2, 1'b0);
        chk(ea, acc, "add");
        r = nx(r);
        opd = r;
        sc = i == 3 ? 4'hf : r[3:0];
        ea = ea & ({16'h0, opd} << sc);
        go(4'h1, 1'b0);
        chk(ea, acc, "and");
    end
    // Mask register, long constant, and a zeroing constant
    for (i = 0; i < 3; i = i + 1) begin
        r = nx(r);
        ad = r[3:0];
        msk = nx(r);
        ulc = i > 0;
        opd = i == 2 ? 16'h0 : r;
        ex = mem.mem[ad] & (ulc ? opd : msk);
        q.push_back(ex);
        go(4'h3, 1'b0);
        issue = 1'b0;
        chk(ex == 16'h0, tf, "flag");
        @(negedge clk);
        chk(ex, mem.mem[ad], "mem");
    end
    // Branch that bumps the register and moves the pointer
    opd = r;
    {hm, md, lp, np} = 7'h6b;
    q.push_back(opd);
    go(4'h4, 1'b0);
    chk(3'h3, aux_reg_pointer, "ptr");
    {hm, lp} = 2'h0;
    // Delayed acc branch; a plain branch in the slot is refused
    q.push_back(acc[15:0]);
    go(4'h5, 1'b1);
    chk(2'h2, dl, "delay");
    {opd, sc, wd} = 21'h1fffe1;
    ea = ea & 32'hffff;
    go(4'h1, 1'b0);
    go(4'h4, 1'b0);
    issue = 1'b0;
    wd = 1'b0;
    chk(ea, acc, "slot");
    @(negedge clk);
    // Zero register: no branch, yet still counted down; then taken old-mode and delayed loop branches
    go(4'h6, 1'b0);
    chk(16'hffff, aux, "aux");
    om = 1'b1;
    q.push_back(opd);
    go(4'h6, 1'b0);
    om = 1'b0;
    q.push_back(opd);
    go(4'h6, 1'b1);
    issue = 1'b0;
    wd = 1'b1;
    repeat (2) @(negedge clk);
    wd = 1'b0;
    @(negedge clk);
    chk(16'hfffd, aux, "aux");
    chk(0, q.size(), "queue");
    stop_test;
end
endmodule // logic_and_branch_exec_bench
